/* File: rtl/telemetry_regs_defs.vh */
// Constants for the motor telemetry readback register bank.
// Assumes a plain address/strobe register port with 14-bit byte addresses holding a 12-bit word index.
`ifndef TELEMETRY_REGS_DEFS_VH
`define TELEMETRY_REGS_DEFS_VH

// Register indices as printed (not all multiples of four: byte address = 4 * index)
`define IDX_PHASE_A_CURRENT 12'h43E
`define IDX_PHASE_B_CURRENT 12'h440
`define IDX_PHASE_C_CURRENT 12'h442
`define IDX_CURRENT_SENSE_GAIN 12'h466
`define IDX_VOLTAGE_SENSE_GAIN 12'h476
`define IDX_SUPPLY_BUS_VOLTAGE 12'h478

// Widths
`define ADDR_W 14
`define DATA_W 32
`define GAIN_W 16
`define IDX_W 12
`define ADDR_IDX_LSB 2

// Reset values
`define RST_WORD 32'h00000000
`define RST_GAIN 16'h0000
`define RESERVED_HALF 16'h0000
`define UNMAPPED_READ 32'h00000000

// Current-sense gain codes (V/A): 1.2, 0.6, 0.3, 0.15
`define CSG_1P2 16'h0000
`define CSG_0P6 16'h0001
`define CSG_0P3 16'h0002
`define CSG_0P15 16'h0003

// Voltage-sense gain codes (full scale): 60 V, 30 V, 15 V
`define VSG_60V 16'h0000
`define VSG_30V 16'h0001
`define VSG_15V 16'h0002

`endif

/* File: rtl/motor_telemetry_readback_regs.v */
// Read-only bank of motor telemetry registers: phase currents, sense gains, supply voltage.
// Assumes the control algorithm supplies values on clk with a one-cycle update strobe,
// and software uses a plain address/strobe port with byte addresses.
//
// Contract
// R1 - Phase A current readable, 32-bit, read-only
// R2 - Phase B current readable, reset zero
// R3 - Phase C current readable, 32-bit, read-only
// R4 - Current gain code low half, upper zero
// R5 - Voltage gain code low half, upper zero
// R6 - Supply bus voltage readable, 32-bit
// R7 - Software writes ignored, no side effects
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_regs_defs.vh"

module motor_telemetry_readback_regs (
    input wire clk,
    input wire rst,
    input wire clk_en,
    // Software register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [`DATA_W-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [`DATA_W-1:0] reg_rdata,
    // Measurement feed from the control algorithm
    input wire meas_update,
    input wire [`DATA_W-1:0] meas_phase_a,
    input wire [`DATA_W-1:0] meas_phase_b,
    input wire [`DATA_W-1:0] meas_phase_c,
    input wire [`GAIN_W-1:0] meas_current_gain,
    input wire [`GAIN_W-1:0] meas_voltage_gain,
    input wire [`DATA_W-1:0] meas_supply_voltage
);

    // Held measurements; only the algorithm feed loads them
    reg [`DATA_W-1:0] phase_a_current;
    reg [`DATA_W-1:0] phase_b_current;
    reg [`DATA_W-1:0] phase_c_current;
    reg [`GAIN_W-1:0] current_sense_gain;
    reg [`GAIN_W-1:0] voltage_sense_gain;
    reg [`DATA_W-1:0] supply_bus_voltage;

    // Word index of the access; low two byte-address bits ignored
    wire [`IDX_W-1:0] word_idx;
    assign word_idx = reg_addr[`ADDR_W-1:`ADDR_IDX_LSB];

    // Read mux result
    reg [`DATA_W-1:0] next_rdata;

    // Write port deliberately unused: whole bank is read-only
    wire unused_write;
    assign unused_write = reg_write ^ (^reg_wdata); // R7

    // Snapshot all values together so a coherent set is seen
    always @(posedge clk) begin
        if (rst) begin
            phase_a_current <= `RST_WORD;
            phase_b_current <= `RST_WORD; // R2
            phase_c_current <= `RST_WORD;
            current_sense_gain <= `RST_GAIN;
            voltage_sense_gain <= `RST_GAIN;
            supply_bus_voltage <= `RST_WORD;
        end else if (clk_en && meas_update) begin
            // Software writes never reach here
            phase_a_current <= meas_phase_a; // R1
            phase_b_current <= meas_phase_b; // R2
            phase_c_current <= meas_phase_c; // R3
            current_sense_gain <= meas_current_gain; // R4
            voltage_sense_gain <= meas_voltage_gain; // R5
            supply_bus_voltage <= meas_supply_voltage; // R6
        end
    end

    // Address decode for reads
    always @* begin
        case (word_idx)
            `IDX_PHASE_A_CURRENT: begin
                next_rdata = phase_a_current; // R1
            end
            `IDX_PHASE_B_CURRENT: begin
                next_rdata = phase_b_current; // R2
            end
            `IDX_PHASE_C_CURRENT: begin
                next_rdata = phase_c_current; // R3
            end
            `IDX_CURRENT_SENSE_GAIN: begin
                // Upper half reserved
                next_rdata = {`RESERVED_HALF, current_sense_gain}; // R4
            end
            `IDX_VOLTAGE_SENSE_GAIN: begin
                next_rdata = {`RESERVED_HALF, voltage_sense_gain}; // R5
            end
            `IDX_SUPPLY_BUS_VOLTAGE: begin
                next_rdata = supply_bus_voltage; // R6
            end
            default: begin
                // Unmapped addresses read zero
                next_rdata = `UNMAPPED_READ;
            end
        endcase
    end

    // Read data stands from the cycle after an enabled strobe until the next clk_en cycle
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `RST_WORD;
        end else if (clk_en) begin
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end else begin
                // Zero otherwise, so stale data is never mistaken
                reg_rdata <= `RST_WORD;
            end
        end
    end

endmodule // motor_telemetry_readback_regs
`default_nettype wire

/* File: dv/motor_telemetry_readback_regs_monitor.sv */
// Checker: a read right after a capture returns the captured word.
// Assumes a bind into the bank, seeing its ports only.
`timescale 1ns/1ps
`default_nettype none
module motor_telemetry_readback_regs_monitor (
    input wire logic clk, rst, clk_en, reg_write, reg_read, meas_update,
    input wire logic [13:0] reg_addr,
    input wire logic [31:0] reg_rdata, meas_phase_a, meas_phase_b, meas_phase_c, meas_supply_voltage,
    input wire logic [15:0] meas_current_gain, meas_voltage_gain);
    wire u = meas_update && clk_en; // Capture taken
    wire rd = reg_read && clk_en; // Read taken
    wire [11:0] ix = reg_addr[13:2]; // Word index, low bits ignored
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_IA: assert property (u ##1 rd && ix == 12'h43E |=> reg_rdata == $past(meas_phase_a, 2))
        else $error("phase a");
    AST_IB: assert property (u ##1 rd && ix == 12'h440 |=> reg_rdata == $past(meas_phase_b, 2))
        else $error("phase b");
    AST_IC: assert property (u ##1 rd && ix == 12'h442 |=> reg_rdata == $past(meas_phase_c, 2))
        else $error("phase c");
    AST_CG: assert property (u ##1 rd && ix == 12'h466 |=> reg_rdata == {16'h0000, $past(meas_current_gain, 2)})
        else $error("current gain");
    AST_VG: assert property (u ##1 rd && ix == 12'h476 |=> reg_rdata == {16'h0000, $past(meas_voltage_gain, 2)})
        else $error("voltage gain");
    AST_SV: assert property (u ##1 rd && ix == 12'h478 |=> reg_rdata == $past(meas_supply_voltage, 2))
        else $error("supply");
    AST_WR: assert property (clk_en && reg_write |=> reg_rdata == 32'h00000000)
        else $error("write gave data");
endmodule // motor_telemetry_readback_regs_monitor
bind motor_telemetry_readback_regs motor_telemetry_readback_regs_monitor i_mon (.*);
`default_nettype wire

/* File: dv/motor_telemetry_readback_regs_tb.sv */
// Bench: random captures, reads and writes after a reset.
// Assumes the bank and its checker compile with it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; $display("mismatch reg_rdata %h %h", e, s); end end
module motor_telemetry_readback_regs_tb;
    logic clk = 0, rst = 1, en = 1, wr = 0, rd = 0, up = 0;
    logic [13:0] ad = 0;
    logic [31:0] v = 0, q, r = 32'hA3FB, ex = 0, m [7] = '{default: 0}; // m: expected words, slot 6 unmapped
    logic [11:0] ix [7] = '{12'h43E, 12'h440, 12'h442, 12'h466, 12'h476, 12'h478, 12'h001};
    int k = 6, n_errors = 0, n_tests = 0;
    // Feed words derived from one draw; the two gains take bits 1:0 and 3:2 of it
    motor_telemetry_readback_regs i_motor_telemetry_readback_regs (.clk(clk), .rst(rst), .clk_en(en),
        .reg_addr(ad), .reg_wdata(~v), .reg_write(wr), .reg_read(rd), .reg_rdata(q), .meas_update(up),
        .meas_phase_a(v), .meas_phase_b(~v), .meas_phase_c(-v), .meas_current_gain({14'h0000, v[1:0]}),
        .meas_voltage_gain({14'h0000, v[3:2]}), .meas_supply_voltage(v ^ 32'h5A5A5A5A));
    function automatic [31:0] xs(input [31:0] s); // Xorshift step
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    initial forever #5 clk = ~clk; // 100 MHz
    task automatic end_of_test;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Predict each answer, then draw the next inputs
    initial begin
        for (int i = 0; i < 600; i++) begin
            @(posedge clk);
            if (rst || en) ex = rst || !rd ? 0 : m[k]; // Idle reads zero, disabled holds
            if (rst) m = '{default: 0};
            else if (en && up) m = '{v, ~v, -v, v[1:0], v[3:2], v ^ 32'h5A5A5A5A, 0};
            r = xs(r);
            k = i == 301 ? 1 : r[10:8] % 7; // Corner: phase B right after mid-run reset
            rst <= i < 5 || i == 300; // Six reset cycles, then one mid-run
            en <= i < 6 || i == 301 || r[7:4] != 0;
            rd <= r[11] || i == 301;
            wr <= !r[11] && r[12] && i != 301; // Writes must change nothing
            ad <= {ix[k], r[5:4]}; // Low bits ignored
            up <= r[13];
            v <= r;
            @(negedge clk);
            `CHK(ex, q)
        end
        $display("random test done");
        end_of_test;
    end
endmodule // motor_telemetry_readback_regs_tb
`default_nettype wire
